// file: pkg/rtcsr_defs.vh
// constants for the status, reset and time-keeping register block
// assumes a byte-wide register port driven by a serial front end
// Behaviour
// - power-on flag, status bit 5, set on power-on reset, cleared by writing zero.
// - recovery-reset flag, status bit 4, set by self-recovery or system reset.
// - low-voltage flags: bit 2 below first threshold, bit 3 below second.
// - unimplemented bits in status, reset and time registers read as zero.
// - time registers hold BCD with separate tens and units digits.
// - seconds at 08h hold BCD 0 to 59 in bits 6..0, bit 7 unused.
// - minutes at 09h hold BCD 0 to 59 in bits 6..0, bit 7 unused.
// - hours bit 6 selects 12-hour; then bit 5 is PM, bits 4..0 hours 1-12.
// - in 24-hour format hours bits 5..0 hold BCD 0 to 23.
`ifndef RTCSR_DEFS_VH
`define RTCSR_DEFS_VH
`define RTCSR_ADDR_STATUS 8'h03
`define RTCSR_ADDR_RESET 8'h04
`define RTCSR_ADDR_SEC 8'h08
`define RTCSR_ADDR_MIN 8'h09
`define RTCSR_ADDR_HOUR 8'h0a
`define RTCSR_BIT_BUSY 7
`define RTCSR_BIT_PON 5
`define RTCSR_BIT_SR 4
`define RTCSR_BIT_V2 3
`define RTCSR_BIT_V1 2
`define RTCSR_BIT_SYSTEM_RESET_TRIGGER 4
`define RTCSR_BIT_FMT12 6
`define RTCSR_BIT_PM 5
`define RTCSR_MASK_STATUS 8'hbc
`define RTCSR_MASK_MS 8'h7f
`define RTCSR_MASK_HOUR 8'h7f
`define RTCSR_RST_SEC 8'h00
`define RTCSR_RST_MIN 8'h00
`define RTCSR_RST_HOUR 8'h00
`define RTCSR_BCD_59 8'h59
`define RTCSR_BCD_23 8'h23
`define RTCSR_BCD_12 8'h12
`define RTCSR_BCD_11 8'h11
`define RTCSR_BCD_01 8'h01
`endif

// file: hdl/rtcsr_bcd_inc.v
// one-digit-pair BCD incrementer with wrap
// assumes a valid packed BCD input
`timescale 1ns/1ps
module rtcsr_bcd_inc (
  // operand
  input wire [7:0] value,
  input wire [7:0] max_value,
  input wire [7:0] wrap_value,
  // result
  output reg [7:0] result,
  output reg carry
);
  always @* begin
    if (value == max_value) begin
      result = wrap_value;
      carry = 1'b1;
    end else if (value[3:0] == 4'h9) begin
      result = {value[7:4] + 4'h1, 4'h0};
      carry = 1'b0;
    end else begin
      result = {value[7:4], value[3:0] + 4'h1};
      carry = 1'b0;
    end
  end
endmodule // rtcsr_bcd_inc

// file: hdl/rtcsr_core.v
// status, reset command and seconds/minutes/hours time-keeping
// assumes a serial front end giving one-cycle byte reads/writes on core_clk
`timescale 1ns/1ps
`include "rtcsr_defs.vh"
module rtcsr_core (
  // clock and reset
  input wire core_clk,
  input wire rst,
  // register port
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  // events from analog and store logic
  input wire tick_1hz,
  input wire below_threshold_one,
  input wire below_threshold_two,
  input wire self_recovery_event,
  input wire store_active,
  // restart request to the rest of the device
  output wire logic_restart
);
  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  reg [4:0] sync_a;
  reg [4:0] sync_b;
  reg tick_last;
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sync_a <= 5'h00;
      sync_b <= 5'h00;
      tick_last <= 1'b0;
    end else begin
      sync_a <= {store_active, self_recovery_event, below_threshold_two,
                 below_threshold_one, tick_1hz};
      sync_b <= sync_a;
      tick_last <= sync_b[0];
    end
  end
  wire tick = sync_b[0] & ~tick_last;
  wire v1_low = sync_b[1];
  wire v2_low = sync_b[2];
  wire recov_lvl = sync_b[3];
  wire busy = sync_b[4];
  reg recov_last;
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      recov_last <= 1'b0;
    end else begin
      recov_last <= recov_lvl;
    end
  end
  wire recov_ev = recov_lvl & ~recov_last;

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  reg power_on_flag;
  reg recovery_reset_flag;
  reg low_voltage_first_flag;
  reg low_voltage_second_flag;
  reg system_reset_trigger;
  reg [7:0] time_seconds;
  reg [7:0] time_minutes;
  reg [7:0] time_hours;

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  wire wr_status = reg_wr && (reg_addr == `RTCSR_ADDR_STATUS);
  wire wr_reset = reg_wr && (reg_addr == `RTCSR_ADDR_RESET);
  wire wr_sec = reg_wr && (reg_addr == `RTCSR_ADDR_SEC);
  wire wr_min = reg_wr && (reg_addr == `RTCSR_ADDR_MIN);
  wire wr_hour = reg_wr && (reg_addr == `RTCSR_ADDR_HOUR);

  // trigger held one cycle then cleared; it is the restart pulse
  assign logic_restart = system_reset_trigger;

  // ------------------------------------------------------------
  // time counting
  // ------------------------------------------------------------
  wire fmt12 = time_hours[`RTCSR_BIT_FMT12];
  wire pm = time_hours[`RTCSR_BIT_PM];
  wire [7:0] hr_val = fmt12 ? {3'b000, time_hours[4:0]}
                            : {2'b00, time_hours[5:0]};
  wire [7:0] sec_next;
  wire [7:0] min_next;
  wire [7:0] hr_inc;
  wire sec_carry;
  wire min_carry;
  rtcsr_bcd_inc u_sec (
    .value(time_seconds & `RTCSR_MASK_MS),
    .max_value(`RTCSR_BCD_59),
    .wrap_value(8'h00),
    .result(sec_next),
    .carry(sec_carry)
  );
  rtcsr_bcd_inc u_min (
    .value(time_minutes & `RTCSR_MASK_MS),
    .max_value(`RTCSR_BCD_59),
    .wrap_value(8'h00),
    .result(min_next),
    .carry(min_carry)
  );
  rtcsr_bcd_inc u_hr (
    .value(hr_val),
    .max_value(fmt12 ? `RTCSR_BCD_12 : `RTCSR_BCD_23),
    .wrap_value(fmt12 ? `RTCSR_BCD_01 : 8'h00),
    .result(hr_inc),
    .carry()
  );
  reg [7:0] next_hours;
  always @* begin
    if (fmt12) begin
      // 11 -> 12 toggles am/pm, 12 -> 1 keeps it
      next_hours = {1'b0, 1'b1, pm ^ (hr_val == `RTCSR_BCD_11),
                    hr_inc[4:0]};
    end else begin
      next_hours = {2'b00, hr_inc[5:0]};
    end
  end

  // ------------------------------------------------------------
  // status flags and restart trigger
  // ------------------------------------------------------------
  // a hardware set wins over a host clear in the same cycle
  function flag_next;
    input cur;
    input hw_set;
    input host_clr;
    begin
      if (hw_set) begin
        flag_next = 1'b1;
      end else if (host_clr) begin
        flag_next = 1'b0;
      end else begin
        flag_next = cur;
      end
    end
  endfunction

  wire clr_pon = wr_status && !reg_wdata[`RTCSR_BIT_PON];
  wire clr_sr = wr_status && !reg_wdata[`RTCSR_BIT_SR];
  wire clr_v1 = wr_status && !reg_wdata[`RTCSR_BIT_V1];
  wire clr_v2 = wr_status && !reg_wdata[`RTCSR_BIT_V2];
  wire set_sr = system_reset_trigger | recov_ev;

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      power_on_flag <= 1'b1;
      recovery_reset_flag <= 1'b0;
      low_voltage_first_flag <= 1'b0;
      low_voltage_second_flag <= 1'b0;
      system_reset_trigger <= 1'b0;
    end else begin
      // only rst sets the power-on flag
      power_on_flag <= flag_next(power_on_flag, 1'b0, clr_pon);
      recovery_reset_flag <= flag_next(recovery_reset_flag, set_sr,
        clr_sr);
      low_voltage_first_flag <= flag_next(low_voltage_first_flag, v1_low,
        clr_v1);
      low_voltage_second_flag <= flag_next(low_voltage_second_flag,
        v2_low, clr_v2);
      if (system_reset_trigger) begin
        system_reset_trigger <= 1'b0;
      end else if (wr_reset) begin
        system_reset_trigger <= reg_wdata[`RTCSR_BIT_SYSTEM_RESET_TRIGGER];
      end
    end
  end

  // ------------------------------------------------------------
  // time register updates
  // ------------------------------------------------------------
  // host write wins over the tick; no range correction
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      time_seconds <= `RTCSR_RST_SEC;
      time_minutes <= `RTCSR_RST_MIN;
      time_hours <= `RTCSR_RST_HOUR;
    end else if (system_reset_trigger) begin
      time_seconds <= `RTCSR_RST_SEC;
      time_minutes <= `RTCSR_RST_MIN;
      time_hours <= `RTCSR_RST_HOUR;
    end else begin
      begin
        if (wr_sec) begin
          time_seconds <= reg_wdata & `RTCSR_MASK_MS;
        end else if (tick) begin
          time_seconds <= sec_next;
        end
        if (wr_min) begin
          time_minutes <= reg_wdata & `RTCSR_MASK_MS;
        end else if (tick && sec_carry) begin
          time_minutes <= min_next;
        end
        if (wr_hour) begin
          time_hours <= reg_wdata & `RTCSR_MASK_HOUR;
        end else if (tick && sec_carry && min_carry) begin
          time_hours <= next_hours;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // read-back
  // ------------------------------------------------------------
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `RTCSR_ADDR_STATUS: reg_rdata <= {busy, 1'b0, power_on_flag,
          recovery_reset_flag, low_voltage_second_flag,
          low_voltage_first_flag, 2'b00};
        `RTCSR_ADDR_RESET: reg_rdata <= {3'b000, system_reset_trigger,
          4'h0};
        `RTCSR_ADDR_SEC: reg_rdata <= time_seconds & `RTCSR_MASK_MS;
        `RTCSR_ADDR_MIN: reg_rdata <= time_minutes & `RTCSR_MASK_MS;
        `RTCSR_ADDR_HOUR: reg_rdata <= time_hours & `RTCSR_MASK_HOUR;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end
endmodule // rtcsr_core

// file: bench/rtcsr_core_assertions.sv
// checker for the register port and restart of rtcsr_core
// assumes it is bound to rtcsr_core and sees only its ports
`timescale 1ns/1ps
module rtcsr_assertions (
  // clock and reset
  input wire core_clk,
  input wire rst,
  // register port
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  // events and restart
  input wire below_threshold_one,
  input wire store_active,
  input wire logic_restart
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  wire rd_st = reg_rd && reg_addr == 8'h03;
  sequence s_cmd;
    reg_wr && reg_addr == 8'h04 && reg_wdata[4];
  endsequence
  sequence s_busy;
    $stable(store_active) [*3] ##0 rd_st;
  endsequence
  property p_pulse;
    s_cmd |=> logic_restart ##1 !logic_restart;
  endproperty
  a_pulse: assert property (p_pulse) else $error("no pulse");
  property p_cause;
    logic_restart |-> $past(reg_wr && reg_addr == 8'h04 && reg_wdata[4]);
  endproperty
  a_cause: assert property (p_cause) else $error("stray pulse");
  property p_sr;
    s_cmd ##2 rd_st |=> reg_rdata[4];
  endproperty
  a_sr: assert property (p_sr) else $error("no recovery flag");
  property p_stat0;
    rd_st |=> !reg_rdata[6] && reg_rdata[1:0] == 2'h0;
  endproperty
  a_stat0: assert property (p_stat0) else $error("status unused");
  property p_time7;
    reg_rd && reg_addr inside {8'h08, 8'h09, 8'h0a} |=> !reg_rdata[7];
  endproperty
  a_time7: assert property (p_time7) else $error("time bit 7");
  property p_unmap;
    reg_rd && !(reg_addr inside {8'h03, 8'h04, 8'h08, 8'h09, 8'h0a})
      |=> reg_rdata == 8'h00;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped");
  property p_busy;
    s_busy |=> reg_rdata[7] == $past(store_active);
  endproperty
  a_busy: assert property (p_busy) else $error("busy flag");
  property p_low;
    below_threshold_one [*5] ##0 rd_st |=> reg_rdata[2];
  endproperty
  a_low: assert property (p_low) else $error("low flag");
endmodule // rtcsr_assertions

// file: bench/rtcsr_host.sv
// host model: single byte reads and writes
// assumes strobes are sampled on rising core_clk
`timescale 1ns/1ps
module rtcsr_host (
  // clock
  input wire core_clk,
  // register port
  output reg reg_wr,
  output reg reg_rd,
  output reg [7:0] reg_addr,
  output reg [7:0] reg_wdata
);
  initial {reg_wr, reg_rd, reg_addr, reg_wdata} = 18'h0_0000;
  // one strobe cycle, then address and data turn to junk
  task acc(input w, input [7:0] a, input [7:0] d);
    @(negedge core_clk);
    {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, !w, a, d};
    @(negedge core_clk);
    {reg_wr, reg_rd} = 2'h0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
endmodule // rtcsr_host

// file: bench/tb.sv
// self-checking bench for rtcsr_core
// assumes rtcsr_host drives the register port
`timescale 1ns/1ps
module tb;
  logic core_clk = 0, rst = 1, rd_q = 0, tick_1hz = 0;
  logic below_threshold_one = 0, below_threshold_two = 0;
  logic self_recovery_event = 0, store_active = 0, logic_restart;
  logic reg_wr, reg_rd;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, pulses = 0, s;
  logic [7:0] exp_q[$];
  logic [15:0] hrs [4] = '{16'h2300, 16'h5172, 16'h7261, 16'h0910};
  integer mismatches = 0, compares = 0, cycles = 0, seed = 36, i;
  always #10 core_clk = ~core_clk;
  rtcsr_core rtcsr_core_i (.core_clk, .rst, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata, .reg_rdata, .tick_1hz, .below_threshold_one,
    .below_threshold_two, .self_recovery_event, .store_active,
    .logic_restart);
  rtcsr_host rtcsr_host_i (.core_clk, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata);
  task check(input [7:0] seen, input [7:0] want);
    compares++;
    if (seen !== want) begin
      mismatches++;
      $display("ERROR %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    rtcsr_host_i.acc(1, a, d);
  endtask
  task rd(input [7:0] a, input [7:0] e);
    exp_q.push_back(e);
    rtcsr_host_i.acc(0, a, 8'h00);
  endtask
  task give_verdict;
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles++;
    rd_q <= reg_rd;
    if (logic_restart)
      pulses++;
    if (cycles == 2000) begin
      mismatches++;
      give_verdict;
    end
  end
  always @(negedge core_clk) if (rd_q) check(reg_rdata, exp_q.pop_front());
  initial begin
    repeat (4) @(negedge core_clk);
    rst = 0;
    rd(8'h03, 8'h20);
    rd(8'h04, 8'h00);
    rd(8'h05, 8'h00);
    wr(8'h03, 8'hdf);
    rd(8'h03, 8'h00);
    for (i = 0; i < 3; i++) begin
      {store_active, below_threshold_two, below_threshold_one} = 3'h1 << i;
      repeat (4) @(negedge core_clk);
      rd(8'h03, i == 2 ? 8'h80 : 8'h04 << i);
      wr(8'h03, 8'h00);
      rd(8'h03, i == 2 ? 8'h80 : 8'h04 << i);
      {store_active, below_threshold_two, below_threshold_one} = 3'h0;
      repeat (4) @(negedge core_clk);
      wr(8'h03, 8'h00);
      rd(8'h03, 8'h00);
    end
    self_recovery_event = 1;
    repeat (4) @(negedge core_clk);
    self_recovery_event = 0;
    rd(8'h03, 8'h10);
    wr(8'h03, 8'h00);
    for (i = 0; i < 6; i++) begin
      s = 8'({$random(seed)} % 6 * 16 + {$random(seed)} % 10);
      wr(8'(8 + i % 2), s | 8'h80);
      rd(8'(8 + i % 2), s);
    end
    for (i = 0; i < 4; i++) begin
      wr(8'h08, 8'h59);
      wr(8'h09, 8'h59);
      wr(8'h0a, hrs[i][15:8]);
      tick_1hz = 1;
      repeat (4) @(negedge core_clk);
      tick_1hz = 0;
      rd(8'h08, 8'h00);
      rd(8'h09, 8'h00);
      rd(8'h0a, hrs[i][7:0]);
    end
    wr(8'h04, 8'hff);
    rd(8'h03, 8'h10);
    rd(8'h04, 8'h00);
    rd(8'h0a, 8'h00);
    check(pulses, 8'h01);
    repeat (2) @(negedge core_clk);
    give_verdict;
  end
endmodule // tb
bind rtcsr_core rtcsr_assertions rtcsr_assertions_i (.core_clk, .rst,
  .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
  .below_threshold_one, .store_active, .logic_restart);
